/* core/mfes_map.svh */
/*
 file: register offsets, field positions, reset values and timing counts
 of the frame error statistics block.
 assumes: included by bare name from core files, definitions only.
*/
`ifndef MFES_MAP_SVH
`define MFES_MAP_SVH

// register offsets (byte addresses, one 32-bit word each)
`define MFES_OFF_CNT_BASE   8'h00   // oversize counter, others follow
`define MFES_CNT_STRIDE     8'h04   // word stride between counters
`define MFES_OFF_CFG        8'h14   // network configuration bits
`define MFES_OFF_INT_STAT   8'h18   // sticky event status, write one to clear
`define MFES_OFF_INT_MASK   8'h1C   // interrupt enable mask

// counter / event indices (also status and mask bit positions)
`define MFES_IDX_OVERSIZE   0
`define MFES_IDX_JABBER     1
`define MFES_IDX_SHORT      2
`define MFES_IDX_SQE        3
`define MFES_IDX_MISMATCH   4
`define MFES_NUM_CNT        5

// configuration field positions
`define MFES_CFG_FULL_DUPLEX_BIT 1   // 0 selects half duplex
`define MFES_CFG_BIG_FRAME_BIT   8   // raises the oversize threshold
`define MFES_CFG_LEN_CHECK_BIT   16  // enables length field checking

// reset values
`define MFES_CFG_RST        32'h0000_0000
`define MFES_STAT_RST       5'h00
`define MFES_MASK_RST       5'h00
`define MFES_RDATA_RST      32'h0000_0000

// frame length thresholds in bytes
`define MFES_LEN_MAX_STD    14'h05EE   // 1518
`define MFES_LEN_MAX_BIG    14'h0600   // 1536
`define MFES_LEN_MIN        14'h0040   // 64
`define MFES_TYPE_ID_MIN    16'h0600   // type field, not a length

// heartbeat window: 96 bit times at 10 Mb/s
`define MFES_SQE_BITS       96
`define MFES_BIT_TIME_NS    100
`define MFES_SQE_WINDOW_NS  (`MFES_SQE_BITS * `MFES_BIT_TIME_NS)
`define MFES_CLK_PERIOD_NS  100
`define MFES_SQE_CYCLES     (`MFES_SQE_WINDOW_NS / `MFES_CLK_PERIOD_NS)

`endif

/* core/mfes_pkg.sv */
/*
 file: types shared by the frame error statistics block.
 assumes: compiled before every other core file.
*/
package mfes_pkg;
    // heartbeat checker states
    typedef enum logic [0:0] {
        MFES_SQE_IDLE = 1'b0,  // waiting for end of transmission
        MFES_SQE_WAIT = 1'b1   // counting the heartbeat window
    } mfes_sqe_state_t;
endpackage

/* core/mfes_sat_counter.sv */
/*
 file: one software-writable saturating statistics counter.
 assumes: single clock, async active-low reset, one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfes_map.svh"

module mfes_sat_counter #(
    parameter int W = 8                      // counter width
) (
    input  wire logic         clk_in,        // system clock
    input  wire logic         rst_n_in,      // async reset, active low
    input  wire logic         inc_in,        // count one event
    input  wire logic         wr_in,         // software load
    input  wire logic [W-1:0] wdata_in,      // value to load
    output var  logic [W-1:0] count_out      // current count
);
    logic [W-1:0] count_q;  // count register
    logic [W-1:0] count_d;  // next count

    // load beats increment so software sees exactly what it wrote
    always_comb begin
        count_d = count_q;
        if (wr_in) begin
            count_d = wdata_in;
        end else if (inc_in && (count_q != '1)) begin
            count_d = count_q + W'(1);
        end
    end

    // count storage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_out = count_q;

    // a full counter stays full until software writes it
    chk_count_saturate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (count_q == '1) && !wr_in |=> (count_q == '1))
        else $error("saturated counter moved without a write");

    // a written value appears on the next cycle
    chk_count_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_in |=> (count_q == $past(wdata_in)))
        else $error("software write not loaded");
endmodule // mfes_sat_counter
`default_nettype wire

/* core/mfes_sqe_check.sv */
/*
 file: heartbeat (SQE test) checker, one error pulse per missing collision.
 assumes: tx enable and collision are synchronous to clk_in, 10 Mb/s.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfes_map.svh"

module mfes_sqe_check #(
    parameter int WIN = `MFES_SQE_CYCLES     // window length in cycles
) (
    input  wire logic clk_in,                // system clock
    input  wire logic rst_n_in,              // async reset, active low
    input  wire logic half_duplex_in,        // checking only in half duplex
    input  wire logic tx_en_in,              // transmit enable
    input  wire logic collision_input_in,    // collision from the phy
    output var  logic sqe_err_out            // one-cycle error pulse
);
    mfes_pkg::mfes_sqe_state_t state_q;      // checker state
    logic [7:0]                cnt_q;        // cycles since tx enable fell
    logic                      tx_en_q;      // tx enable one cycle ago
    logic                      err_q;        // error pulse register
    logic                      tx_fall;      // end of a transmission

    assign tx_fall = tx_en_q && !tx_en_in;

    // previous tx enable for edge detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_en_q <= 1'b0;
        end else begin
            tx_en_q <= tx_en_in;
        end
    end

    // window state machine; the falling cycle is window cycle zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= mfes_pkg::MFES_SQE_IDLE;
            cnt_q   <= 8'h00;
            err_q   <= 1'b0;
        end else begin
            err_q <= 1'b0;
            case (state_q)
                mfes_pkg::MFES_SQE_IDLE: begin
                    // a heartbeat right on the edge already passes
                    if (tx_fall && half_duplex_in && !collision_input_in) begin
                        state_q <= mfes_pkg::MFES_SQE_WAIT;
                        cnt_q   <= 8'h01;
                    end
                end
                mfes_pkg::MFES_SQE_WAIT: begin
                    if (collision_input_in || tx_en_in || !half_duplex_in) begin
                        // heartbeat seen, or window cut short by a new frame
                        state_q <= mfes_pkg::MFES_SQE_IDLE;
                    end else if (cnt_q == 8'(WIN - 1)) begin
                        err_q   <= 1'b1;
                        state_q <= mfes_pkg::MFES_SQE_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                default: begin
                    state_q <= mfes_pkg::MFES_SQE_IDLE;
                end
            endcase
        end
    end

    assign sqe_err_out = err_q;

    // end of transmission with the heartbeat already present
    sequence s_fall_with_col;
        tx_fall && half_duplex_in && collision_input_in;
    endsequence

    // heartbeat on the edge gives no error in the next 8 cycles
    chk_sqe_heartbeat_ok: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_fall_with_col |=> !err_q [*8])
        else $error("error raised despite heartbeat");

    // an error only ever follows a full window in the wait state
    chk_sqe_error_timing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(err_q) |-> $past(cnt_q) == 8'(WIN - 1))
        else $error("heartbeat error at the wrong time");
endmodule // mfes_sqe_check
`default_nettype wire

/* core/mfes_top.sv */
/*
 file: frame error statistics block of an ethernet mac: oversize, jabber,
 undersize, heartbeat error and length mismatch counters with interrupts.
 counters are 8 bits by default; their upper read bits are zero.
 assumes: one 10 MHz clock, receive status given as one pulse per frame at
 its end, mii transmit enable and collision synchronous to the clock.
*/
// Strobed register access and the register addresses were left to the implementer.
// Contract
// - count error-free frames above the oversize threshold
// - count errored frames above the oversize threshold
// - count error-free frames shorter than 64 bytes
// - count missing heartbeat within 96 bit times
// - count frames shorter than their length field
// - length check only while config bit 16
// - skip type fields and oversize frames
`timescale 1ns/1ps
`default_nettype none
`include "mfes_map.svh"

module mfes_top #(
    parameter int CNT_W   = 8,                  // counter width
    parameter int SQE_WIN = `MFES_SQE_CYCLES    // heartbeat window, cycles
) (
    input  wire logic        CLOCK_IN,              // system clock
    input  wire logic        RESETN_IN,             // async reset, active low
    // register bus
    input  wire logic [7:0]  ADDR_IN,               // register byte address
    input  wire logic [31:0] WDATA_IN,              // write data
    input  wire logic        WR_IN,                 // write strobe
    input  wire logic        RD_IN,                 // read strobe
    output var  logic [31:0] RDATA_OUT,             // read data, next cycle
    output var  logic        IRQ_OUT,               // level interrupt

    // receive frame status
    input  wire logic        RX_DONE_IN,            // frame status valid
    input  wire logic [13:0] RX_LEN_IN,             // measured length, bytes
    input  wire logic [15:0] RX_LEN_TYPE_IN,        // bytes 13 and 14
    input  wire logic        RX_CRC_ERR_IN,         // fcs error
    input  wire logic        RX_ALIGN_ERR_IN,       // alignment error
    input  wire logic        RX_SYM_ERR_IN,         // symbol error seen

    // mii transmit side
    input  wire logic        TX_EN_IN,              // mii transmit enable
    input  wire logic        COLLISION_INPUT_IN     // mii collision
);
    localparam int N = `MFES_NUM_CNT;  // number of counters

    // configuration and interrupt registers
    logic [31:0]      cfg_q;           // network configuration bits
    logic [N-1:0]     stat_q;          // sticky event bits
    logic [N-1:0]     stat_d;          // next sticky bits
    logic [N-1:0]     mask_q;          // interrupt mask
    logic [N-1:0]     mask_d;          // next mask
    logic             irq_q;           // interrupt output register
    logic [31:0]      rdata_q;         // read data register
    logic [31:0]      rdata_d;         // read mux

    // counter plumbing
    logic [N-1:0]     ev;              // one-cycle event per counter
    logic [N-1:0]     cnt_wr;          // software write per counter
    logic [CNT_W-1:0] cnt [N];         // counter values

    // frame classification
    logic             big_frames;      // 1536-byte threshold selected
    logic             len_check_en;    // length checking enabled
    logic             half_duplex;     // heartbeat test active
    logic             rx_err;          // any receive error
    logic             rx_over;         // above oversize threshold
    logic             rx_under;        // under minimum length
    logic             rx_is_len;       // bytes 13/14 hold a length
    logic             rx_mismatch;     // shorter than its length field
    logic             sqe_err;         // heartbeat missing
    logic [13:0]      max_len;         // selected oversize threshold

    assign big_frames   = cfg_q[`MFES_CFG_BIG_FRAME_BIT];
    assign len_check_en = cfg_q[`MFES_CFG_LEN_CHECK_BIT];
    assign half_duplex  = !cfg_q[`MFES_CFG_FULL_DUPLEX_BIT];

    // receive frame classification, valid on the status pulse
    always_comb begin
        // threshold follows config bit 8 per frame
        max_len     = big_frames ? `MFES_LEN_MAX_BIG : `MFES_LEN_MAX_STD;
        // any error turns a long frame into a jabber
        rx_err      = RX_CRC_ERR_IN || RX_ALIGN_ERR_IN || RX_SYM_ERR_IN;
        rx_over     = RX_LEN_IN > max_len;
        rx_under    = RX_LEN_IN < `MFES_LEN_MIN;
        rx_is_len   = RX_LEN_TYPE_IN < `MFES_TYPE_ID_MIN;
        // oversize frames are never length mismatches
        rx_mismatch = len_check_en && rx_is_len && !rx_over
                      && ({2'b00, RX_LEN_IN} < RX_LEN_TYPE_IN);
    end

    // events that advance the counters
    always_comb begin
        ev = '0;
        // receive events need the status pulse
        ev[`MFES_IDX_OVERSIZE] = RX_DONE_IN && rx_over && !rx_err;
        ev[`MFES_IDX_JABBER]   = RX_DONE_IN && rx_over && rx_err;
        ev[`MFES_IDX_SHORT]    = RX_DONE_IN && rx_under && !rx_err;
        ev[`MFES_IDX_SQE]      = sqe_err;
        ev[`MFES_IDX_MISMATCH] = RX_DONE_IN && rx_mismatch;
    end

    // heartbeat checker on the transmit side
    mfes_sqe_check #(
        .WIN(SQE_WIN)
    ) u_sqe (
        .clk_in             (CLOCK_IN),
        .rst_n_in           (RESETN_IN),
        // full duplex turns the test off
        .half_duplex_in     (half_duplex),
        .tx_en_in           (TX_EN_IN),
        .collision_input_in (COLLISION_INPUT_IN),
        .sqe_err_out        (sqe_err)
    );

    // one saturating counter per statistic, decoded at its own word
    for (genvar i = 0; i < N; i++) begin : g_cnt
        localparam logic [7:0] OFF = 8'(`MFES_OFF_CNT_BASE + i * `MFES_CNT_STRIDE);
        // a write here beats a same-cycle event
        assign cnt_wr[i] = WR_IN && (ADDR_IN == OFF);
        mfes_sat_counter #(
            .W(CNT_W)
        ) u_cnt (
            .clk_in    (CLOCK_IN),
            .rst_n_in  (RESETN_IN),
            .inc_in    (ev[i]),
            .wr_in     (cnt_wr[i]),
            .wdata_in  (WDATA_IN[CNT_W-1:0]),
            .count_out (cnt[i])
        );
    end

    // configuration register, plain read-write
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cfg_q <= `MFES_CFG_RST;
        end else if (WR_IN && (ADDR_IN == `MFES_OFF_CFG)) begin
            // all bits kept, three decoded
            cfg_q <= WDATA_IN;
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        stat_d = stat_q;
        if (WR_IN && (ADDR_IN == `MFES_OFF_INT_STAT)) begin
            // write one to clear
            stat_d = stat_d & ~WDATA_IN[N-1:0];
        end
        // set applied last so it wins
        stat_d = stat_d | ev;
        // mask is plain read-write
        mask_d = mask_q;
        if (WR_IN && (ADDR_IN == `MFES_OFF_INT_MASK)) begin
            mask_d = WDATA_IN[N-1:0];
        end
    end

    // status, mask and interrupt; irq follows the new values directly
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            // nothing pending, nothing enabled
            stat_q <= `MFES_STAT_RST;
            mask_q <= `MFES_MASK_RST;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            // next values: irq rises with its bit
            irq_q  <= |(stat_d & mask_d);
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        // counters on a regular word stride
        for (int k = 0; k < N; k++) begin
            if (ADDR_IN == 8'(`MFES_OFF_CNT_BASE + k * `MFES_CNT_STRIDE)) begin
                rdata_d = 32'(cnt[k]);
            end
        end
        // control words decoded apart
        case (ADDR_IN)
            `MFES_OFF_CFG:      rdata_d = cfg_q;
            `MFES_OFF_INT_STAT: rdata_d = 32'(stat_q);
            `MFES_OFF_INT_MASK: rdata_d = 32'(mask_q);
            default:            rdata_d = rdata_d;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_q <= `MFES_RDATA_RST;
        end else if (RD_IN) begin
            // word picked by the strobe
            rdata_q <= rdata_d;
        end else begin
            // zero keeps stale data off the bus
            rdata_q <= 32'h0000_0000;
        end
    end

    assign RDATA_OUT = rdata_q;
    assign IRQ_OUT   = irq_q;

    // checks below share one clock and reset
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);

    // headroom left in each counter
    logic [N-1:0] room;
    for (genvar j = 0; j < N; j++) begin : g_room
        // full or being written: no step
        assign room[j] = (cnt[j] != '1) && !cnt_wr[j];
    end

    // error-free oversize frame advances the oversize count
    chk_oversize_count: assert property (
        RX_DONE_IN && (RX_LEN_IN > max_len) && !rx_err && room[0]
        |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
        else $error("oversize frame not counted");

    // errored oversize frame advances jabber, not oversize
    chk_jabber_count: assert property (
        RX_DONE_IN && (RX_LEN_IN > max_len) && rx_err && room[1] && !cnt_wr[0]
        |=> cnt[1] == $past(cnt[1]) + CNT_W'(1)
        && $stable(cnt[0]))
        else $error("jabber frame miscounted");

    // clean runt frame advances the undersize count
    chk_short_count: assert property (
        RX_DONE_IN && (RX_LEN_IN < `MFES_LEN_MIN) && !rx_err && room[2]
        |=> cnt[2] == $past(cnt[2]) + CNT_W'(1))
        else $error("undersize frame not counted");

    // a heartbeat error reaches its counter on the next cycle
    chk_sqe_count: assert property (
        sqe_err && room[3]
        |=> cnt[3] == $past(cnt[3]) + CNT_W'(1))
        else $error("heartbeat error not counted");

    // short-of-length-field frame counted when checking is on
    chk_mismatch_count: assert property (
        RX_DONE_IN && len_check_en && rx_is_len && !rx_over && room[4]
        && ({2'b00, RX_LEN_IN} < RX_LEN_TYPE_IN)
        |=> cnt[4] == $past(cnt[4]) + CNT_W'(1))
        else $error("length mismatch not counted");

    // with checking off the mismatch count never moves by itself
    chk_len_check_off: assert property (
        !len_check_en && !cnt_wr[4]
        |=> $stable(cnt[4]))
        else $error("mismatch counted with checking off");

    // type fields and oversize frames never count as mismatches
    chk_type_field_skip: assert property (
        RX_DONE_IN && (!rx_is_len || rx_over) && !cnt_wr[4]
        |=> $stable(cnt[4]))
        else $error("type field or oversize counted as mismatch");

    // interrupt follows an unmasked event within one cycle
    chk_irq_event: assert property (
        |(ev & mask_d)
        |=> IRQ_OUT && |(stat_q & mask_q))
        else $error("interrupt missing after unmasked event");

    // errored long frames stay out of the oversize count
    chk_oversize_err: assert property (
        RX_DONE_IN && rx_over && rx_err && !cnt_wr[0] |=> $stable(cnt[0]))
        else $error("errored long frame counted");

    // errored runts stay out of the undersize count
    chk_short_err: assert property (
        RX_DONE_IN && rx_under && rx_err && !cnt_wr[2] |=> $stable(cnt[2]))
        else $error("errored runt counted");

    // read data falls back to zero after its cycle
    chk_rdata_idle: assert property (
        !RD_IN |=> RDATA_OUT == 32'h0000_0000)
        else $error("stale read data");

    // no unmasked pending bit, no interrupt
    chk_irq_quiet: assert property (
        !(|(stat_d & mask_d)) |=> !IRQ_OUT)
        else $error("interrupt without cause");

    // pending bits stay until written away
    chk_stat_sticky: assert property (
        !(WR_IN && (ADDR_IN == `MFES_OFF_INT_STAT))
        |=> (stat_q & $past(stat_q)) == $past(stat_q))
        else $error("pending bit lost");

    // the mask moves only when written
    chk_mask_hold: assert property (
        !(WR_IN && (ADDR_IN == `MFES_OFF_INT_MASK)) |=> $stable(mask_q))
        else $error("mask moved unwritten");
endmodule // mfes_top
`default_nettype wire

/* verif/mfes_phy_model.sv */
/*
 file: phy side model, answers each end of transmit with a heartbeat unless the delay is ff.
 assumes: one clock shared with the block, delay set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module mfes_phy_model (
    input  wire logic       clk_in,    // system clock
    input  wire logic       rst_n_in,  // async reset, active low
    input  wire logic       tx_en_in,  // mac transmit enable
    input  wire logic [7:0] hb_dly_in, // heartbeat delay, ff means none
    output var  logic       col_out    // collision line, low when idle
);
    logic       tx_q;  // last transmit enable
    logic       arm_q; // heartbeat still owed
    logic [7:0] cnt_q; // cycles since transmit ended

    // one heartbeat pulse per transmission, prompt or slow or missing
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_q <= 1'b0;
            arm_q <= 1'b0;
            cnt_q <= 8'h00;
            col_out <= 1'b0;
        end else begin
            tx_q <= tx_en_in;
            col_out <= 1'b0;
            if (tx_q && !tx_en_in) begin
                // end of frame: start the heartbeat delay
                arm_q <= (hb_dly_in != 8'hFF);
                cnt_q <= 8'h00;
            end else if (arm_q) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == hb_dly_in) begin
                    col_out <= 1'b1;
                    arm_q <= 1'b0;
                end
            end
        end
    end
endmodule // mfes_phy_model

`default_nettype wire

/* verif/mfes_tb_top.sv */
/*
 file: self-checking bench of the frame error statistics block.
 assumes: map header on the include path, short heartbeat window of 8.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfes_map.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module mfes_tb_top;
    logic        clk, rst_n, wr, rd, irq, rx_done, crc, aln, sym, tx_en, col;
    logic [7:0]  addr, hb_dly;  // bus address, heartbeat delay
    logic [31:0] wdata, rdata;  // bus data
    logic [13:0] rx_len;        // measured length
    logic [15:0] rx_lt;         // length or type field
    logic [31:0] seed = 32'h0000_01FA; // xorshift state
    logic [31:0] exp_q[$];      // expected read data, oldest first
    logic [31:0] got;           // random draw
    logic [31:0] want;          // popped read expectation
    logic [4:0]  exp_st;        // expected sticky status
    int          exp_c[5];      // expected counters
    int          errors, total_checks, cyc;
    logic        rd_prev, big, lchk; // read pending, config copies

    mfes_top #(.CNT_W(8), .SQE_WIN(8)) u_dut (.CLOCK_IN(clk), .RESETN_IN(rst_n),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .IRQ_OUT(irq), .RX_DONE_IN(rx_done), .RX_LEN_IN(rx_len), .RX_LEN_TYPE_IN(rx_lt),
        .RX_CRC_ERR_IN(crc), .RX_ALIGN_ERR_IN(aln), .RX_SYM_ERR_IN(sym),
        .TX_EN_IN(tx_en), .COLLISION_INPUT_IN(col));
    mfes_phy_model u_phy (.clk_in(clk), .rst_n_in(rst_n), .tx_en_in(tx_en),
        .hb_dly_in(hb_dly), .col_out(col));

    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // monitor: read data checked against the oldest expectation in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_prev) begin
            want = exp_q.pop_front();
            `CHK(rdata, want)
        end
        rd_prev = rd;
    end

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // strobe a read and note what must come back
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic set_cfg(input logic [31:0] v);
        wr_reg(`MFES_OFF_CFG, v);
        big = v[8];
        lchk = v[16];
    endtask

    // saturating expectation, 8-bit counters stop at ff
    task automatic bump(input int i);
        if (exp_c[i] < 255) exp_c[i]++;
        exp_st[i] = 1'b1;
    endtask

    // one frame status pulse and its expected effect
    task automatic frame(input logic [13:0] l, input logic [15:0] t, input logic [2:0] e);
        logic [13:0] mx;
        mx = big ? 14'h0600 : 14'h05EE;
        @(posedge clk);
        rx_done <= 1'b1;
        rx_len <= l;
        rx_lt <= t;
        {crc, aln, sym} <= e;
        @(posedge clk);
        rx_done <= 1'b0;
        if (l > mx && e == 3'h0) bump(0);
        if (l > mx && e != 3'h0) bump(1);
        if (l < 14'h0040 && e == 3'h0) bump(2);
        if (lchk && t < 16'h0600 && l <= mx && {2'h0, l} < t) bump(4);
    endtask

    task automatic chk_cnt();
        for (int i = 0; i < 5; i++) begin
            rd_reg(8'(4 * i), 32'(exp_c[i]));
        end
        rd_reg(`MFES_OFF_INT_STAT, {27'h000_0000, exp_st});
    endtask

    task automatic irq_chk(input logic e);
        @(negedge clk);
        `CHK(irq, e)
    endtask

    // transmit burst, the phy answers after d cycles
    task automatic tx_burst(input logic [7:0] d);
        hb_dly <= d;
        @(posedge clk);
        tx_en <= 1'b1;
        repeat (4) @(posedge clk);
        tx_en <= 1'b0;
        repeat (20) @(posedge clk);
    endtask

    // main sequence
    initial begin
        {rst_n, wr, rd, rx_done, crc, aln, sym, tx_en, rd_prev, big, lchk} = '0;
        {addr, hb_dly, wdata, rx_len, rx_lt, exp_st} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk_cnt();
        rd_reg(`MFES_OFF_CFG, 32'h0000_0000);
        rd_reg(`MFES_OFF_INT_MASK, 32'h0000_0000);
        rd_reg(8'h20, 32'h0000_0000);
        // thresholds at 1518 and 64, every error kind, check off
        frame(14'h05EF, 16'h0000, 3'h0);
        frame(14'h05EE, 16'h0000, 3'h0);
        frame(14'h05EF, 16'h0000, 3'h4);
        frame(14'h05EF, 16'h0000, 3'h2);
        frame(14'h05EF, 16'h0000, 3'h1);
        frame(14'h003F, 16'h0000, 3'h0);
        frame(14'h0040, 16'h0000, 3'h0);
        frame(14'h003F, 16'h0000, 3'h1);
        frame(14'h0064, 16'h00C8, 3'h0);
        chk_cnt();
        // length check on, standard threshold
        set_cfg(32'h0001_0000);
        frame(14'h0064, 16'h00C8, 3'h0);
        frame(14'h0064, 16'h0600, 3'h0);
        frame(14'h0064, 16'h05FF, 3'h0);
        frame(14'h00C8, 16'h00C8, 3'h0);
        frame(14'h05EF, 16'h05FF, 3'h0);
        // big frames: 1536 fits, 1537 does not
        set_cfg(32'h0001_0100);
        frame(14'h0600, 16'h0000, 3'h0);
        frame(14'h0601, 16'h0000, 3'h0);
        frame(14'h0601, 16'h0000, 3'h2);
        for (int i = 0; i < 40; i++) begin
            got = rnd();
            frame(14'(got[26:16]), 16'(got[10:0]), (got[4:3] == 2'h0) ? got[2:0] : 3'h0);
        end
        chk_cnt();
        // interrupt: raise, clear, mask
        wr_reg(`MFES_OFF_INT_MASK, 32'h0000_001F);
        irq_chk(|exp_st);
        wr_reg(`MFES_OFF_INT_STAT, 32'h0000_001F);
        exp_st = 5'h00;
        irq_chk(1'b0);
        wr_reg(`MFES_OFF_INT_MASK, 32'h0000_0004);
        frame(14'h0700, 16'h0000, 3'h0);
        irq_chk(1'b0);
        frame(14'h000A, 16'h0000, 3'h0);
        irq_chk(1'b1);
        wr_reg(`MFES_OFF_INT_STAT, 32'h0000_0004);
        exp_st[2] = 1'b0;
        irq_chk(1'b0);
        // heartbeat: prompt, slow, missing, then full duplex
        set_cfg(32'h0000_0000);
        tx_burst(8'h02);
        tx_burst(8'h05);
        tx_burst(8'hFF);
        bump(3);
        set_cfg(32'h0000_0002);
        tx_burst(8'hFF);
        chk_cnt();
        // software load, then saturation at ff
        wr_reg(`MFES_OFF_CNT_BASE, 32'h0000_00FE);
        exp_c[0] = 254;
        frame(14'h0700, 16'h0000, 3'h0);
        frame(14'h0700, 16'h0000, 3'h0);
        chk_cnt();
        for (int i = 0; i < 5; i++) begin
            got = rnd();
            wr_reg(8'(4 * i), got);
            rd_reg(8'(4 * i), {24'h00_0000, got[7:0]});
        end
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule // mfes_tb_top

`default_nettype wire
